// ==== pkg/usr_consts.svh ====
// Constants for the status read command block.
`ifndef USR_CONSTS_SVH
`define USR_CONSTS_SVH

`define USR_CMD_FRAME        8'hb4
`define USR_CMD_IDENT        8'hb5
`define USR_CMD_IRQ          8'hc0

`define USR_FRAME_BYTES      3'h2
`define USR_IDENT_BYTES      3'h2
`define USR_IRQ_BYTES        3'h4

`define USR_FRAME_RESET      16'h0000
`define USR_IRQ_RESET        32'h00000000
`define USR_FLAGS_RESET      6'h00
`define USR_FRAME_HI_W       3

`define USR_BIT_BUSRESET     0
`define USR_BIT_RESUME       1
`define USR_BIT_SUSPEND      2
`define USR_BIT_DMADONE      3
`define USR_BIT_SOF          4
`define USR_BIT_MISSED       5
`define USR_BIT_BUSSTATE     7
`define USR_BIT_EP_BASE      8
`define USR_EP_COUNT         16

`define USR_RD_CLEAR_MASK    6'h3f

`define USR_CLK_PERIOD_NS    100
`define USR_FRAME_TIME_NS    1000000
`define USR_FRAME_CYCLES     (`USR_FRAME_TIME_NS / `USR_CLK_PERIOD_NS)
`define USR_MISS_LIMIT       2'h3

`endif

// ==== pkg/usr_pkg.sv ====
// Types shared by the status read command block.
`default_nettype none
package usr_pkg;
	typedef enum logic [1:0] {
		USR_SEL_NONE,
		USR_SEL_FRAME,
		USR_SEL_IDENT,
		USR_SEL_IRQ
	} usr_sel_type;
endpackage : usr_pkg
`default_nettype wire

// ==== pkg/usr_evt_if.sv ====
// Bus event signals between the core and the frame watchdog.
`timescale 1ns/100ps
`default_nettype none
interface usr_evt_if;
	logic sofPulse;
	logic busResetPulse;
	logic resumePulse;
	logic missPulse;
	logic suspended;
	modport watch (input sofPulse, input busResetPulse, input resumePulse, output missPulse, output suspended);
	modport core  (output sofPulse, output busResetPulse, output resumePulse, input missPulse, input suspended);
endinterface : usr_evt_if
`default_nettype wire

// ==== hdl/usr_sof_watch.sv ====
// Watchdog for missing start-of-frame tokens and bus suspension.
`timescale 1ns/100ps
`default_nettype none
`include "usr_consts.svh"
module usr_sof_watch #(
	parameter int FRAME_CYCLES = `USR_FRAME_CYCLES,
	parameter int CNT_W        = 16
) (
	// Clock and control.
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clkEn,
	// Bus events.
	usr_evt_if.watch  ev
);
	logic [CNT_W-1:0] tick_reg;
	logic [1:0]       miss_reg;
	logic             missPulse_reg;
	logic             susp_reg;
	logic             restart;
	logic             frameEnd;

	assign restart  = ev.sofPulse | ev.busResetPulse | ev.resumePulse;
	assign frameEnd = (tick_reg == CNT_W'(FRAME_CYCLES - 1));
	assign ev.missPulse = missPulse_reg;
	assign ev.suspended = susp_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tick_reg <= '0;
		end else if (clkEn) begin
			if (restart || frameEnd) begin
				tick_reg <= '0;
			end else begin
				tick_reg <= tick_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			miss_reg      <= 2'h0;
			missPulse_reg <= 1'b0;
			susp_reg      <= 1'b0;
		end else if (clkEn) begin
			missPulse_reg <= 1'b0;
			if (restart) begin
				miss_reg <= 2'h0;
				susp_reg <= 1'b0;
			end else if (frameEnd) begin
				missPulse_reg <= 1'b1;
				if (miss_reg != `USR_MISS_LIMIT) begin
					miss_reg <= miss_reg + 2'h1;
				end
				if (miss_reg == `USR_MISS_LIMIT - 2'h1) begin
					susp_reg <= 1'b1;
				end
			end
		end
	end

	sequence sofSeen;
		clkEn && ev.sofPulse;
	endsequence

	sequence watchRestarted;
		!susp_reg && miss_reg == 2'h0;
	endsequence

	suspend_on_third_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(susp_reg) |-> missPulse_reg && miss_reg == `USR_MISS_LIMIT)
		else $error("Suspension entered without the third missed frame.");

	sof_restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sofSeen |=> watchRestarted)
		else $error("Start of frame did not restart the watchdog.");
endmodule : usr_sof_watch
`default_nettype wire

// ==== hdl/usr_status_read.sv ====
// Status read commands: frame number, chip identification, interrupt sources.
// Overview of operation
// - Frame-number command returns number from last error-free start-of-frame token.
// - After frame command, one or two bytes read, low byte first.
// - After bus reset, stored frame number undefined until a good token.
// - Frame word 16 bits, low byte 7:0, bits 10:8 upper, 15:11 reserved.
// - Identification command returns two bytes of identity and hardware version.
// - Identification word 16 bits, high byte 15:8, low byte 7:0.
// - Interrupt command returns four bytes of the 32-bit source register.
// - Bits 23:10 flag endpoints 14..1, bit 9 control IN, 8 control OUT.
// - Bit 7 follows bus state: 0 awake, 1 suspended.
// - Bit 5 flags missed frame every millisecond; three misses enter suspend.
// - Bit 4 set when a start-of-frame is detected.
// - Bit 3 set when DMA transfer counter reaches zero.
// - Bit 2 set on transition from awake to suspended.
// - Bit 1 set when resume signalling is detected.
// - Bit 0 set on bus reset; all bits zero after device reset.
// - Interrupt read clears event flags; endpoint flags cleared by endpoint status read.
// - Events raise interrupt output only when enabled.
`timescale 1ns/100ps
`default_nettype none
`include "usr_consts.svh"
module usr_status_read #(
	parameter int          FRAME_CYCLES = `USR_FRAME_CYCLES,
	parameter logic [15:0] CHIP_IDENT   = 16'h5a01 // Arbitrary value.
) (
	// Clock, reset and enable.
	input  wire logic                         clk_sys,
	input  wire logic                         sys_rst,
	input  wire logic                         clkEn,
	// Parallel command and data port.
	input  wire logic                         cmdDataSelect,
	input  wire logic                         wrStrobe,
	input  wire logic                         rdStrobe,
	input  wire logic [7:0]                   dataIn,
	output var  logic [7:0]                   dataOut,
	output var  logic                         dataOe,
	// Bus events from the serial engine.
	input  wire logic                         sofGood,
	input  wire logic [10:0]                  sofFrame,
	input  wire logic                         busResetEvt,
	input  wire logic                         resumeEvt,
	input  wire logic                         dmaCountZero,
	input  wire logic [`USR_EP_COUNT-1:0]     epEvent,
	input  wire logic [`USR_EP_COUNT-1:0]     epStatusRead,
	// Interrupt enables and output.
	input  wire logic [23:0]                  intEnable,
	output var  logic                         irqOut,
	output var  logic                         busSuspended
);
	import usr_pkg::*;

	usr_evt_if evIf ();

	usr_pkg::usr_sel_type          sel_reg;
	logic [15:0]                   frame_reg;
	logic [5:0]                    flags_reg;
	logic [`USR_EP_COUNT-1:0]      epFlags_reg;
	logic                          suspPrev_reg;
	logic [31:0]                   snap_reg;
	logic [2:0]                    idx_reg;
	logic [2:0]                    limit_reg;
	logic [7:0]                    dataOut_reg;
	logic                          dataOe_reg;
	logic                          irq_reg;
	logic                          cmdTaken;
	logic                          rdTaken;
	logic                          irqRead;
	logic [5:0]                    evtSet;
	logic [31:0]                   irqWord;
	logic [31:0]                   cmdWord;
	logic [2:0]                    cmdLimit;
	logic [2:0]                    nextIdx;
	usr_pkg::usr_sel_type          cmdSel;

	// Returns the byte at an index of a word, or zero past the last byte.
	function automatic logic [7:0] pickByte(input logic [31:0] word, input logic [2:0] idx,
		input logic [2:0] limit);
		logic [7:0] b;
		b = 8'h00;
		if (idx < limit) begin
			b = word[idx[1:0]*8 +: 8];
		end
		return b;
	endfunction : pickByte

	assign evIf.sofPulse      = sofGood;
	assign evIf.busResetPulse = busResetEvt;
	assign evIf.resumePulse   = resumeEvt;

	usr_sof_watch #(
		.FRAME_CYCLES (FRAME_CYCLES),
		.CNT_W        (16)
	) uWatch (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.ev      (evIf.watch)
	);

	assign cmdTaken = clkEn && wrStrobe && cmdDataSelect;
	assign rdTaken  = clkEn && rdStrobe && !cmdDataSelect && sel_reg != USR_SEL_NONE;
	assign irqRead  = cmdTaken && dataIn == `USR_CMD_IRQ;
	assign nextIdx  = (idx_reg == 3'h7) ? 3'h7 : idx_reg + 3'h1;

	// Live interrupt word with reserved bits zero.
	assign irqWord = {8'h00, epFlags_reg, evIf.suspended, 1'b0, flags_reg};

	// Event sources for the sticky flags.
	always_comb begin
		evtSet = 6'h00;
		evtSet[`USR_BIT_BUSRESET] = busResetEvt;
		evtSet[`USR_BIT_RESUME]   = resumeEvt;
		evtSet[`USR_BIT_SUSPEND]  = evIf.suspended && !suspPrev_reg;
		evtSet[`USR_BIT_DMADONE]  = dmaCountZero;
		evtSet[`USR_BIT_SOF]      = sofGood;
		evtSet[`USR_BIT_MISSED]   = evIf.missPulse;
	end

	// Command code decode into a selected word.
	always_comb begin
		cmdSel   = USR_SEL_NONE;
		cmdWord  = 32'h00000000;
		cmdLimit = 3'h0;
		if (dataIn == `USR_CMD_FRAME) begin
			cmdSel   = USR_SEL_FRAME;
			cmdWord  = {16'h0000, frame_reg};
			cmdLimit = `USR_FRAME_BYTES;
		end else if (dataIn == `USR_CMD_IDENT) begin
			cmdSel   = USR_SEL_IDENT;
			cmdWord  = {16'h0000, CHIP_IDENT};
			cmdLimit = `USR_IDENT_BYTES;
		end else if (dataIn == `USR_CMD_IRQ) begin
			cmdSel   = USR_SEL_IRQ;
			cmdWord  = irqWord;
			cmdLimit = `USR_IRQ_BYTES;
		end
	end

	// Frame number capture from good tokens only.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			frame_reg <= `USR_FRAME_RESET;
		end else if (clkEn && sofGood) begin
			// Upper reserved bits held at zero.
			frame_reg <= {5'h00, sofFrame};
		end
	end

	// Sticky event flags, set wins over read clear.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags_reg    <= `USR_FLAGS_RESET;
			suspPrev_reg <= 1'b0;
		end else if (clkEn) begin
			suspPrev_reg <= evIf.suspended;
			flags_reg <= (flags_reg & ~(irqRead ? `USR_RD_CLEAR_MASK : 6'h00)) | evtSet;
		end
	end

	// Endpoint flags cleared by endpoint status reads.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			epFlags_reg <= '0;
		end else if (clkEn) begin
			epFlags_reg <= (epFlags_reg & ~epStatusRead) | epEvent;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_reg     <= USR_SEL_NONE;
			snap_reg    <= 32'h00000000;
			idx_reg     <= 3'h0;
			limit_reg   <= 3'h0;
			dataOut_reg <= 8'h00;
			dataOe_reg  <= 1'b0;
		end else if (cmdTaken) begin
			sel_reg     <= cmdSel;
			snap_reg    <= cmdWord;
			idx_reg     <= 3'h0;
			limit_reg   <= cmdLimit;
			dataOut_reg <= pickByte(cmdWord, 3'h0, cmdLimit);
			dataOe_reg  <= cmdSel != USR_SEL_NONE;
		end else if (rdTaken) begin
			idx_reg     <= nextIdx;
			dataOut_reg <= pickByte(snap_reg, nextIdx, limit_reg);
		end
	end

	// Enabled events drive the interrupt output.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_reg <= 1'b0;
		end else if (clkEn) begin
			irq_reg <= |(irqWord[23:0] & intEnable);
		end
	end

	assign dataOut      = dataOut_reg;
	assign dataOe       = dataOe_reg;
	assign irqOut       = irq_reg;
	assign busSuspended = evIf.suspended;

	sequence frameCmd;
		cmdTaken && dataIn == `USR_CMD_FRAME;
	endsequence

	sequence frameSecondRead;
		frameCmd ##1 rdTaken;
	endsequence

	sequence identCmd;
		cmdTaken && dataIn == `USR_CMD_IDENT;
	endsequence

	frame_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		sofGood |=> frame_reg[10:0] == $past(sofFrame))
		else $error("Frame number not captured from good token.");

	frame_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		frameCmd |=> dataOut == $past(frame_reg[7:0]) && dataOe)
		else $error("Frame low byte not presented first.");

	frame_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		frameSecondRead |=> dataOut == {5'h00, $past(frame_reg[10:8], 2)})
		else $error("Frame high byte not presented second.");

	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		frame_reg[15:11] == 5'h00 && irqWord[31:24] == 8'h00 && !irqWord[6])
		else $error("Reserved bit not zero.");

	ident_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		identCmd |=> dataOut == CHIP_IDENT[7:0] && dataOe)
		else $error("Identification low byte not presented first.");

	ident_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		identCmd ##1 rdTaken |=> dataOut == CHIP_IDENT[15:8])
		else $error("Identification high byte not presented second.");

	irq_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irqRead |=> dataOut == $past(irqWord[7:0]) && snap_reg == $past(irqWord))
		else $error("Interrupt word not snapshot on command.");

	read_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irqRead && evtSet == 6'h00 |=> flags_reg == 6'h00)
		else $error("Interrupt read did not clear event flags.");

	endpoint_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		epEvent != '0 |=> (epFlags_reg & $past(epEvent)) == $past(epEvent))
		else $error("Endpoint event lost.");

	suspend_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		$rose(evIf.suspended) |=> flags_reg[`USR_BIT_SUSPEND])
		else $error("Suspend entry not flagged.");

	bus_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		busResetEvt |=> flags_reg[`USR_BIT_BUSRESET] ##0 irqWord[`USR_BIT_BUSRESET])
		else $error("Bus reset not flagged.");

	dma_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		dmaCountZero |=> flags_reg[`USR_BIT_DMADONE])
		else $error("DMA completion not flagged.");

	sof_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		sofGood |=> flags_reg[`USR_BIT_SOF])
		else $error("Start of frame not flagged.");

	resume_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		resumeEvt |=> flags_reg[`USR_BIT_RESUME])
		else $error("Resume not flagged.");

	missed_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		evIf.missPulse |=> flags_reg[`USR_BIT_MISSED])
		else $error("Missed frame not flagged.");

	endpoint_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clkEn)
		(epStatusRead & ~epEvent) != '0 |=> (epFlags_reg & $past(epStatusRead & ~epEvent)) == '0)
		else $error("Endpoint flag not cleared by its status read.");

	unknown_cmd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmdTaken && cmdSel == USR_SEL_NONE |=> !dataOe && dataOut == 8'h00)
		else $error("Unknown command left the data bus driven.");

	freeze_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!clkEn |=> $stable(dataOut) && $stable(frame_reg) && $stable(flags_reg) && $stable(epFlags_reg))
		else $error("State changed while the clock enable was low.");
endmodule : usr_status_read
`default_nettype wire

// ==== verification/usr_host_model.sv ====
// Controller model that issues command codes and reads data bytes.
`timescale 1ns/100ps
`default_nettype none
module usr_host_model (
	// Clock.
	input  wire logic       clk_sys,
	// Command and data port.
	output var  logic       cmdDataSelect,
	output var  logic       wrStrobe,
	output var  logic       rdStrobe,
	output var  logic [7:0] dataIn,
	input  wire logic [7:0] dataOut
);
	initial begin
		cmdDataSelect = 1'b0;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		dataIn = 8'h00;
	end

	task automatic send_cmd(input logic [7:0] code);
		@(posedge clk_sys);
		#10;
		cmdDataSelect = 1'b1;
		wrStrobe = 1'b1;
		dataIn = code;
		@(posedge clk_sys);
		#10;
		wrStrobe = 1'b0;
		cmdDataSelect = 1'b0;
		dataIn = ~code;
	endtask : send_cmd

	task automatic read_bytes(input int n, output logic [39:0] got);
		got = 40'h0;
		rdStrobe = 1'b1;
		for (int i = 0; i < n; i++) begin
			got[8*i +: 8] = dataOut;
			@(posedge clk_sys);
			#10;
		end
		rdStrobe = 1'b0;
	endtask : read_bytes
endmodule : usr_host_model
`default_nettype wire

// ==== verification/usr_status_read_tb.sv ====
// Self-checking testbench for the status read command block.
`timescale 1ns/100ps
`default_nettype none
module usr_status_read_tb;
	import usr_pkg::*;
	localparam int          FRAMES = 20;
	localparam logic [15:0] IDENT  = 16'h3c96; // Arbitrary value.
	logic        clk_sys;
	logic        sys_rst;
	logic        clkEn;
	logic        cmdDataSelect;
	logic        wrStrobe;
	logic        rdStrobe;
	logic [7:0]  dataIn;
	logic [7:0]  dataOut;
	logic        dataOe;
	logic        sofGood;
	logic [10:0] sofFrame;
	logic        busResetEvt;
	logic        resumeEvt;
	logic        dmaCountZero;
	logic [15:0] epEvent;
	logic [15:0] epStatusRead;
	logic [23:0] intEnable;
	logic        irqOut;
	logic        busSuspended;
	logic [39:0] got;
	int          n_errors;
	int          num_checks;

	usr_status_read #(.FRAME_CYCLES(FRAMES), .CHIP_IDENT(IDENT)) DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
		.cmdDataSelect(cmdDataSelect), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.sofGood(sofGood), .sofFrame(sofFrame), .busResetEvt(busResetEvt),
		.resumeEvt(resumeEvt), .dmaCountZero(dmaCountZero), .epEvent(epEvent),
		.epStatusRead(epStatusRead), .intEnable(intEnable), .irqOut(irqOut),
		.busSuspended(busSuspended)
	);

	usr_host_model host (
		.clk_sys(clk_sys), .cmdDataSelect(cmdDataSelect), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .dataIn(dataIn), .dataOut(dataOut)
	);

	always #50 clk_sys = ~clk_sys;

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask : step

	task automatic rd(input logic [7:0] code, input int n);
		host.send_cmd(code);
		host.read_bytes(n, got);
	endtask : rd

	// Pulses sof, bus reset, resume and DMA events (bits 0 to 3) plus endpoint events.
	task automatic pulse(input logic [3:0] which, input logic [15:0] ep, input logic [15:0] epRd);
		step(1);
		{dmaCountZero, resumeEvt, busResetEvt, sofGood} = which;
		epEvent = ep;
		epStatusRead = epRd;
		step(1);
		{dmaCountZero, resumeEvt, busResetEvt, sofGood} = 4'h0;
		epEvent = 16'h0000;
		epStatusRead = 16'h0000;
	endtask : pulse

	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		final_report();
	end

	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		clkEn = 1'b1;
		{dmaCountZero, resumeEvt, busResetEvt, sofGood} = 4'h0;
		sofFrame = 11'h000;
		epEvent = 16'h0000;
		epStatusRead = 16'h0000;
		intEnable = 24'h000008;
		n_errors = 0;
		num_checks = 0;
		step(12);
		sys_rst = 1'b0;
		rd(8'hc0, 4);
		check("irq word at reset", 32'h0, got[31:0]);
		rd(8'hb4, 2);
		check("frame at reset", 32'h0, got[31:0]);
		sofFrame = 11'h7a5;
		pulse(4'h1, 16'h0, 16'h0);
		sofFrame = 11'h3ff;
		rd(8'hb4, 3);
		check("frame bytes", 32'h000007a5, got[31:0]);
		check("drive enable", 32'h1, {31'h0, dataOe});
		rd(8'hb4, 1);
		check("frame one byte", 32'h000000a5, got[31:0]);
		rd(8'hb5, 3);
		check("ident bytes", {16'h0, IDENT}, got[31:0]);
		pulse(4'h4, 16'h0, 16'h0);
		rd(8'hc0, 4);
		pulse(4'hb, 16'h8003, 16'h0);
		step(2);
		check("irq raised", 32'h1, {31'h0, irqOut});
		rd(8'hc0, 4);
		check("irq events", 32'h00800319, got[31:0]);
		pulse(4'h0, 16'h0, 16'h0001);
		step(2);
		check("irq cleared", 32'h0, {31'h0, irqOut});
		rd(8'hc0, 4);
		check("irq after clear", 32'h00800200, got[31:0]);
		step(70);
		check("suspended", 32'h1, {31'h0, busSuspended});
		rd(8'hc0, 4);
		check("irq suspend", 32'h008002a4, got[31:0]);
		pulse(4'h4, 16'h0, 16'h0);
		step(1);
		check("awake", 32'h0, {31'h0, busSuspended});
		rd(8'hc0, 4);
		check("irq resume", 32'h00000002, got[31:0] & 32'h00000086);
		rd(8'h00, 1);
		check("unknown command", 32'h0, {23'h0, dataOe, got[7:0]});
		step(1);
		clkEn = 1'b0;
		rd(8'hb4, 2);
		clkEn = 1'b1;
		check("frozen port", 32'h0, {15'h0, dataOe, got[15:0]});
		pulse(4'h8, 16'h0, 16'h0);
		step(2);
		check("irq before reset", 32'h1, {31'h0, irqOut});
		sys_rst = 1'b1;
		step(2);
		sys_rst = 1'b0;
		check("outputs after reset", 32'h0, {21'h0, dataOut, dataOe, irqOut, busSuspended});
		rd(8'hc0, 4);
		check("irq after reset", 32'h0, got[31:0]);
		rd(8'hb4, 2);
		check("frame after reset", 32'h0, got[31:0]);
		final_report();
	end
endmodule : usr_status_read_tb
`default_nettype wire
